// *** dv/acc_checker.sv ***
// Port-level assertions for the comparator control block.
// Bound into acc_top; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module acc_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic output_pad_enable,
    input wire logic output_initial_value,
    input wire logic [7:0] reference_code,
    input wire logic [2:0] negative_input_select,
    input wire logic compare_interrupt_enable,
    input wire logic flag_write_strobe,
    input wire logic flag_write_data,
    input wire logic [1:0] sleep_mode,
    input wire logic [7:0] core_reference_code,
    input wire logic core_use_reference,
    input wire logic out_pin_o,
    input wire logic out_pin_oe,
    input wire logic level_event,
    input wire logic compare_state,
    input wire logic compare_interrupt_flag,
    input wire logic interrupt_request
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_EVT: assert property (level_event == out_pin_o)
        else $error("event differs from output");
    AST_STATE: assert property ($stable(out_pin_o)[*5] |-> compare_state == out_pin_o)
        else $error("state bit not following output");
    AST_HOLD: assert property ((!enable && $stable(output_initial_value))[*3]
        |-> out_pin_o == output_initial_value)
        else $error("disabled output not at initial level");
    AST_EDGE: assert property ($rose(compare_interrupt_flag) |-> $changed(out_pin_o))
        else $error("flag set without output edge");
    AST_STICKY: assert property (compare_interrupt_flag && !(flag_write_strobe && flag_write_data)
        |=> compare_interrupt_flag)
        else $error("flag lost without clear");
    AST_OE: assert property (sleep_mode == 2'h3 || !output_pad_enable |=> !out_pin_oe)
        else $error("pad driven while off");
    AST_REF: assert property ($past(rst_b) |-> core_reference_code == $past(reference_code))
        else $error("reference code not forwarded");
    AST_USEREF: assert property ($past(rst_b)
        |-> core_use_reference == ($past(negative_input_select) == 3'h4))
        else $error("reference select wrong");
    AST_REQ_ON: assert property (compare_interrupt_flag && $past(compare_interrupt_flag)
        && compare_interrupt_enable && $past(compare_interrupt_enable)
        |-> interrupt_request)
        else $error("request dropped with flag set");
    AST_REQ_OFF: assert property (!compare_interrupt_enable && !$past(compare_interrupt_enable)
        |-> !interrupt_request)
        else $error("request while disabled");
    AST_REQ_FLAG: assert property (!compare_interrupt_flag |-> !interrupt_request)
        else $error("request without flag");
endmodule
bind acc_top acc_checker u_acc_checker (.*);
`default_nettype wire

// *** dv/acc_core_model.sv ***
// Behavioural analog core seen by the comparator control block.
// Voltages in mV come from the bench; divider reference is modelled.
`timescale 1ns/100ps
`default_nettype none
module acc_core_model #(
    parameter int VREF_MV = 2048
) (
    input wire logic core_enable,
    input wire logic core_use_reference,
    input wire logic [7:0] core_reference_code,
    input wire logic [11:0] pos_mv,
    input wire logic [11:0] neg_mv,
    output logic core_raw_result
);
    logic [19:0] neg_v;
    logic last;
    initial last = 1'b0;
    // Negative side: pin voltage or code/256 of the reference
    assign neg_v = core_use_reference ? ((20'(core_reference_code) * VREF_MV) >> 8)
                                      : 20'(neg_mv);
    // Unpowered core output is meaningless, so show the inverse of the last level
    always @(negedge core_enable) last = (20'(pos_mv) > neg_v);
    assign core_raw_result = core_enable ? (20'(pos_mv) > neg_v) : ~last;
endmodule
`default_nettype wire

// *** dv/acc_top_tb.sv ***
// Self-checking bench for acc_top with a behavioural analog core.
// Start-up count shortened to 4 cycles.
`timescale 1ns/100ps
`default_nettype none
module acc_top_tb;
    logic clk, rst_b, enable, run_in_standby, output_pad_enable, output_invert;
    logic output_initial_value, compare_interrupt_enable, flag_write_strobe, flag_write_data;
    logic core_raw_result, core_enable, core_use_reference, out_pin_o, out_pin_oe;
    logic level_event, compare_state, compare_interrupt_flag, interrupt_request;
    logic [1:0] power_profile, hysteresis_select, interrupt_edge_select, sleep_mode;
    logic [1:0] core_hysteresis, core_power_profile;
    logic [2:0] positive_input_select, negative_input_select;
    logic [2:0] core_positive_select, core_negative_select;
    logic [7:0] reference_code, core_reference_code;
    logic [11:0] pos_mv, neg_mv;
    int n_mismatch, comparisons;
    logic pin_level;
    // Port keeps the pin as a low output whenever the pad drive is off
    assign pin_level = out_pin_oe ? out_pin_o : 1'b0;

    acc_top #(.STARTUP_CYC(4)) u_acc_top (.*);
    acc_core_model u_acc_core_model (.*);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Sample 1 ns after the edge so registered outputs have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic setv(input logic hi);
        @(posedge clk);
        pos_mv <= hi ? 12'h3e8 : 12'h0c8;
    endtask
    task automatic clr(input logic d);
        @(posedge clk);
        flag_write_strobe <= 1'b1;
        flag_write_data <= d;
        @(posedge clk);
        flag_write_strobe <= 1'b0;
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_start();
        output_initial_value <= 1'b1;
        setv(1'b0);
        enable <= 1'b1;
        tick(2);
        chk("initial out", 1, out_pin_o);
        chk("initial event", 1, level_event);
        tick(14);
        chk("ready out", 0, out_pin_o);
        output_invert <= 1'b1;
        tick(8);
        chk("inverted out", 1, out_pin_o);
        tick(4);
        chk("state bit", 1, compare_state);
        output_invert <= 1'b0;
        output_initial_value <= 1'b0;
        tick(8);
    endtask
    task automatic t_edges();
        logic [1:0] code;
        for (int i = 0; i < 4; i++) begin
            code = i[1:0];
            interrupt_edge_select <= code;
            clr(1'b1);
            setv(1'b1);
            tick(10);
            chk("flag rise", code == 2'h0 || code == 2'h3, compare_interrupt_flag);
            chk("request off", 0, interrupt_request);
            clr(1'b1);
            setv(1'b0);
            tick(10);
            chk("flag fall", code == 2'h0 || code == 2'h2, compare_interrupt_flag);
        end
    endtask
    task automatic t_irq();
        interrupt_edge_select <= 2'h3;
        compare_interrupt_enable <= 1'b1;
        clr(1'b1);
        setv(1'b1);
        tick(10);
        chk("request", 1, interrupt_request);
        tick(20);
        chk("request held", 1, interrupt_request);
        clr(1'b0);
        tick(2);
        chk("flag kept", 1, compare_interrupt_flag);
        clr(1'b1);
        tick(2);
        chk("flag cleared", 0, compare_interrupt_flag);
        chk("request gone", 0, interrupt_request);
        setv(1'b0);
        tick(10);
        chk("no fall hit", 0, compare_interrupt_flag);
    endtask
    task automatic t_sleep();
        interrupt_edge_select <= 2'h0;
        sleep_mode <= 2'h1;
        output_pad_enable <= 1'b1;
        clr(1'b1);
        setv(1'b1);
        tick(10);
        chk("idle request", 1, interrupt_request);
        chk("pad drive", 1, out_pin_oe);
        sleep_mode <= 2'h2;
        tick(4);
        chk("standby out", 0, out_pin_o);
        run_in_standby <= 1'b1;
        tick(20);
        chk("standby run", 1, out_pin_o);
        sleep_mode <= 2'h3;
        tick(3);
        chk("powerdown pad", 0, out_pin_oe);
        chk("port pin", 0, pin_level);
        sleep_mode <= 2'h0;
        tick(3);
        chk("pad back", 1, out_pin_oe);
    endtask
    task automatic t_fwd();
        for (int i = 0; i < 4; i++) begin
            hysteresis_select <= i[1:0];
            power_profile <= ~i[1:0];
            tick(2);
            chk("hysteresis", i[1:0], core_hysteresis);
            chk("power", {6'h00, ~i[1:0]}, core_power_profile);
        end
        negative_input_select <= 3'h4;
        reference_code <= 8'h40;
        positive_input_select <= 3'h1;
        tick(2);
        chk("use ref", 1, core_use_reference);
        chk("pos reserved", 0, core_positive_select);
        tick(10);
        chk("low ref out", 1, out_pin_o);
        reference_code <= 8'hff;
        tick(10);
        chk("high ref out", 0, out_pin_o);
    endtask

    initial begin
        {rst_b, enable, run_in_standby, output_pad_enable, output_invert} = '0;
        {output_initial_value, compare_interrupt_enable, flag_write_strobe} = '0;
        {flag_write_data, power_profile, hysteresis_select, interrupt_edge_select} = '0;
        {sleep_mode, positive_input_select, negative_input_select} = '0;
        reference_code = 8'hff;
        pos_mv = 12'h0c8;
        neg_mv = 12'h1f4;
        tick(2);
        rst_b <= 1'b1;
        tick(1);
        chk("reset ref", 8'hff, core_reference_code);
        chk("reset flag", 0, compare_interrupt_flag);
        t_start();
        t_edges();
        t_irq();
        t_sleep();
        t_fwd();
        close_out();
    end

    // Whole run needs well under 1000 cycles
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire

// *** hw/acc_edge.sv ***
// Edge detector selecting rising, falling or both per the edge code.
// Assumes its input is already synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module acc_edge (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hold,
    input wire logic hold_level,
    input wire logic level_in,
    input wire logic [1:0] edge_sel,
    output logic hit
);
    logic prev_reg;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prev_reg <= 1'b0;
        end else if (hold) begin
            prev_reg <= hold_level;
        end else begin
            prev_reg <= level_in;
        end
    end
    always_comb begin
        hit = 1'b0;
        if (!hold) begin
            unique case (edge_sel)
                acc_pkg::EDGE_BOTH: hit = level_in ^ prev_reg;
                acc_pkg::EDGE_FALL: hit = prev_reg & ~level_in;
                acc_pkg::EDGE_RISE: hit = ~prev_reg & level_in;
                default: hit = 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** hw/acc_pkg.sv ***
// Constants shared by the comparator control block.
// Assumes a 200 MHz core clock and software-facing settings as plain ports.
package acc_pkg;

    // ------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------
    localparam int unsigned MUX_W = 3;
    localparam int unsigned HYS_W = 2;
    localparam int unsigned PWR_W = 2;
    localparam int unsigned REF_W = 8;
    localparam int unsigned EDGE_W = 2;
    localparam logic [7:0] REF_CODE_RESET = 8'hff;

    // Interrupt edge selection codes
    localparam logic [1:0] EDGE_BOTH = 2'h0;
    localparam logic [1:0] EDGE_RSVD = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_RISE = 2'h3;

    // Positive input: analog pins only
    localparam logic [2:0] POS_PIN0 = 3'h0;
    localparam logic [2:0] POS_PIN3 = 3'h3;
    localparam logic [2:0] POS_PIN4 = 3'h4;
    // Negative input: analog pins or divider reference
    localparam logic [2:0] NEG_PIN0 = 3'h0;
    localparam logic [2:0] NEG_PIN2 = 3'h2;
    localparam logic [2:0] NEG_PIN3 = 3'h3;
    localparam logic [2:0] NEG_REF = 3'h4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 200;
    // Comparator start-up time, ns; least time so rounded up
    localparam int unsigned STARTUP_NS = 1000;
    localparam int unsigned STARTUP_CYC = (STARTUP_NS * CLK_MHZ + 999) / 1000;
    // Status synchroniser depth
    localparam int unsigned SYNC_STAGES = 3;

    // Sleep modes
    typedef enum logic [1:0] {
        ACC_SLEEP_ACTIVE,
        ACC_SLEEP_IDLE,
        ACC_SLEEP_STANDBY,
        ACC_SLEEP_PDOWN
    } acc_sleep_t;

endpackage

// *** hw/acc_sync.sv ***
// Three-stage synchroniser for a level from outside the clock domain.
// Output changes only once the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none
module acc_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic init_level,
    input wire logic async_in,
    output logic sync_out
);
    logic [2:0] stage_reg;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stage_reg <= 3'h0;
        end else begin
            stage_reg <= {stage_reg[1:0], async_in};
        end
    end
    // Stage 0 feeds only stage 1
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync_out <= 1'b0;
        end else if (stage_reg[1] == stage_reg[2]) begin
            sync_out <= stage_reg[2];
        end else begin
            sync_out <= sync_out;
        end
    end
    // init_level kept for a defined value later in the pipe; unused here
    logic unused_init;
    assign unused_init = init_level;
endmodule
`default_nettype wire

// *** hw/acc_top.sv ***
// Control logic around an analog voltage comparator core.
// Assumes settings arrive as plain ports and the raw result is asynchronous.
// ------------------------------------------------------------
// What this block does
// [RULE_01] Raw result is 1 when positive input exceeds negative, else 0.
// [RULE_02] Output is raw result XORed with the invert setting.
// [RULE_03] Before the core is ready the output shows the initial value.
// [RULE_04] Software selects inputs, then pad enable, then writes enable.
// [RULE_05] Pad enable drives the comparator output onto the pin.
// [RULE_06] Hysteresis off or three increasing levels, passed to the core.
// [RULE_07] Positive input from pins only; negative from pins or reference.
// [RULE_08] Reference code of 8 bits sets code/256 of reference voltage.
// [RULE_09] Power profile trades response time for current, forwarded.
// [RULE_10] Level event follows the final output level.
// [RULE_11] The block consumes no events; it only generates one.
// [RULE_12] Rising, falling or both edges chosen as interrupt condition.
// [RULE_13] Each condition sets the flag regardless of interrupt enable.
// [RULE_14] Interrupt requested while flag set and enable is 1.
// [RULE_15] Request stays active until software clears the flag.
// [RULE_16] In Idle sleep the block operates normally.
// [RULE_17] Standby disables the block unless run in standby is set.
// [RULE_18] Power-down disables the comparator and its pad drive.
// [RULE_19] Software configures the pin as port output to avoid floating.
// [RULE_20] Edge codes: 0 both, 2 falling, 3 rising, 1 reserved.
// [RULE_21] Writing 1 clears the flag; writing 0 leaves it.
// [RULE_22] State bit mirrors output through a three-cycle synchroniser.
// [RULE_23] Disabled or not ready: output, event, edges held at initial.
// ------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module acc_top #(
    parameter int unsigned STARTUP_CYC = acc_pkg::STARTUP_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    // Software settings
    input wire logic enable,
    input wire logic run_in_standby,
    input wire logic output_pad_enable,
    input wire logic [1:0] power_profile,
    input wire logic [1:0] hysteresis_select,
    input wire logic output_invert,
    input wire logic output_initial_value,
    input wire logic [2:0] positive_input_select,
    input wire logic [2:0] negative_input_select,
    input wire logic [7:0] reference_code,
    input wire logic [1:0] interrupt_edge_select,
    input wire logic compare_interrupt_enable,
    input wire logic flag_write_strobe,
    input wire logic flag_write_data,
    input wire logic [1:0] sleep_mode,
    // Analog core
    input wire logic core_raw_result,
    output logic core_enable,
    output logic [1:0] core_hysteresis,
    output logic [1:0] core_power_profile,
    output logic [2:0] core_positive_select,
    output logic [2:0] core_negative_select,
    output logic core_use_reference,
    output logic [7:0] core_reference_code,
    // Pin, event and status
    output logic out_pin_o,
    output logic out_pin_oe,
    output logic level_event,
    output logic compare_state,
    output logic compare_interrupt_flag,
    output logic interrupt_request
);
    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    logic run;
    logic pad_allowed;
    always_comb begin
        unique case (acc_pkg::acc_sleep_t'(sleep_mode))
            acc_pkg::ACC_SLEEP_ACTIVE: run = enable;
            acc_pkg::ACC_SLEEP_IDLE: run = enable; // RULE_16
            acc_pkg::ACC_SLEEP_STANDBY: run = enable & run_in_standby; // RULE_17
            acc_pkg::ACC_SLEEP_PDOWN: run = 1'b0; // RULE_18
        endcase
        pad_allowed = (sleep_mode != 2'(acc_pkg::ACC_SLEEP_PDOWN)); // RULE_18
    end

    // ------------------------------------------------------------
    // Start-up counter
    // ------------------------------------------------------------
    localparam int unsigned CW = $clog2(STARTUP_CYC + 1);
    logic [CW-1:0] start_cnt_reg;
    logic ready_reg;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            start_cnt_reg <= '0;
            ready_reg <= 1'b0;
        end else if (!run) begin
            start_cnt_reg <= '0;
            ready_reg <= 1'b0;
        end else if (start_cnt_reg == CW'(STARTUP_CYC)) begin
            ready_reg <= 1'b1; // RULE_03
        end else begin
            start_cnt_reg <= start_cnt_reg + CW'(1);
        end
    end

    // ------------------------------------------------------------
    // Forward settings to the analog core
    // ------------------------------------------------------------
    logic pos_ok;
    always_comb begin
        pos_ok = (positive_input_select == acc_pkg::POS_PIN0) ||
                 (positive_input_select == acc_pkg::POS_PIN3) ||
                 (positive_input_select == acc_pkg::POS_PIN4); // RULE_07
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            core_enable <= 1'b0;
            core_hysteresis <= '0;
            core_power_profile <= '0;
            core_positive_select <= acc_pkg::POS_PIN0;
            core_negative_select <= acc_pkg::NEG_PIN0;
            core_use_reference <= 1'b0;
            core_reference_code <= acc_pkg::REF_CODE_RESET;
        end else begin
            core_enable <= run;
            core_hysteresis <= hysteresis_select; // RULE_06
            core_power_profile <= power_profile; // RULE_09
            // Reserved positive codes fall back to pin 0
            core_positive_select <= pos_ok ? positive_input_select : acc_pkg::POS_PIN0; // RULE_07
            core_negative_select <= negative_input_select; // RULE_07
            core_use_reference <= (negative_input_select == acc_pkg::NEG_REF); // RULE_07
            core_reference_code <= reference_code; // RULE_08
        end
    end

    // ------------------------------------------------------------
    // Output path
    // ------------------------------------------------------------
    // The raw result is 1 only when positive exceeds negative; it is
    // synchronised before use so edges are counted exactly once.
    logic raw_sync;
    acc_sync u_raw_sync (
        .clk(clk),
        .rst_b(rst_b),
        .init_level(output_initial_value),
        .async_in(core_raw_result), // RULE_01
        .sync_out(raw_sync)
    );
    logic final_level;
    logic hold;
    always_comb begin
        hold = !(run && ready_reg); // RULE_23
        final_level = hold ? output_initial_value : (raw_sync ^ output_invert); // RULE_02 RULE_03
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            out_pin_o <= 1'b0;
            out_pin_oe <= 1'b0;
            level_event <= 1'b0;
        end else begin
            out_pin_o <= final_level;
            out_pin_oe <= output_pad_enable & pad_allowed; // RULE_05 RULE_18
            // Event is generated only; nothing is taken in from events
            level_event <= final_level; // RULE_10 RULE_11
        end
    end

    // ------------------------------------------------------------
    // Status mirror
    // ------------------------------------------------------------
    // Output level already lives in clk, but the mirror keeps the
    // three-cycle lag software expects.
    // The status flop itself is the last of the three stages
    logic [acc_pkg::SYNC_STAGES-2:0] state_pipe_reg;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_pipe_reg <= '0;
            compare_state <= 1'b0;
        end else begin
            state_pipe_reg <= (acc_pkg::SYNC_STAGES-1)'({state_pipe_reg, final_level});
            compare_state <= state_pipe_reg[acc_pkg::SYNC_STAGES-2]; // RULE_22
        end
    end

    // ------------------------------------------------------------
    // Interrupt flag
    // ------------------------------------------------------------
    logic edge_hit;
    acc_edge u_edge (
        .clk(clk),
        .rst_b(rst_b),
        .hold(hold),
        .hold_level(output_initial_value),
        .level_in(final_level),
        .edge_sel(interrupt_edge_select), // RULE_12 RULE_20
        .hit(edge_hit)
    );

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            compare_interrupt_flag <= 1'b0;
        end else if (edge_hit) begin
            // Set wins over a clear in the same cycle
            compare_interrupt_flag <= 1'b1; // RULE_13
        end else if (flag_write_strobe && flag_write_data) begin
            compare_interrupt_flag <= 1'b0; // RULE_21
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            interrupt_request <= 1'b0;
        end else begin
            // Level request, dropped only by flag clear or disable
            // Follow the flag's own next value so a clear drops both together
            interrupt_request <= compare_interrupt_enable &
                                 ((compare_interrupt_flag &
                                   ~(flag_write_strobe & flag_write_data)) |
                                  edge_hit); // RULE_14 RULE_15
        end
    end

endmodule
`default_nettype wire
